// ---- hdl/t3rt_pkg.sv ----
/*
 Shared constants for the reload/capture timer: register addresses,
 control bit positions, reset values and divider ratios.
 Assumes an 8-bit special-register port with 8-bit addresses.
*/
package t3rt_pkg;

	// Register addresses on the special-register port
	localparam logic [7:0] ADDR_CTRL = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

	// Control register bit positions
	localparam int BIT_HIGH_FLAG = 7;
	localparam int BIT_LOW_FLAG = 6;
	localparam int BIT_LOW_IRQ_EN = 5;
	localparam int BIT_CAPTURE_EN = 4;
	localparam int BIT_SPLIT_EN = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_CAPTURE_SRC = 1;
	localparam int BIT_EXT_CLK_SEL = 0;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	// Byte limits
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	localparam logic [7:0] BYTE_ONE = 8'h01;

	// Divider ratio for the slow internal count source
	localparam int SYS_DIV = 12;

endpackage

// ---- hdl/t3rt_edge_sync.sv ----
/*
 Three-stage synchroniser with rising-edge detector.
 Assumes the input is asynchronous to clock; a change counts once
 the second and third stages agree.
*/
`timescale 1ns/1ps
module t3rt_edge_sync (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic asyncIn,
	output logic risePulse
);

	logic stage1Reg;
	logic stage2Reg;
	logic stage3Reg;
	logic stableReg;
	logic riseReg;
	wire agree = (stage2Reg == stage3Reg);
	wire stableNext = agree ? stage3Reg : stableReg;
	wire riseNext = agree & stage3Reg & ~stableReg;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			stage1Reg <= 1'b0;
			stage2Reg <= 1'b0;
			stage3Reg <= 1'b0;
			stableReg <= 1'b0;
			riseReg <= 1'b0;
		end else begin
			stage1Reg <= asyncIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
			stableReg <= stableNext;
			riseReg <= riseNext;
		end
	end

	assign risePulse = riseReg;

endmodule

// ---- hdl/t3rt_prescale.sv ----
/*
 Free-running divider giving a one-cycle enable every DIV clocks.
 Assumes a single clock with synchronous active-low reset.
*/
`timescale 1ns/1ps
module t3rt_prescale #(
	parameter int DIV = t3rt_pkg::SYS_DIV
) (
	input wire logic clock,
	input wire logic reset_n,
	output logic tick
);

	localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam logic [W-1:0] ZERO = W'(0);
	localparam logic [W-1:0] ONE = W'(1);

	logic [W-1:0] countReg;
	logic tickReg;
	wire atLast = (countReg == LAST);
	wire [W-1:0] countNext = atLast ? ZERO : countReg + ONE;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			countReg <= ZERO;
			tickReg <= 1'b0;
		end else begin
			countReg <= countNext;
			tickReg <= atLast;
		end
	end

	assign tick = tickReg;

endmodule

// ---- hdl/t3rt_timer.sv ----
/*
 Reload/capture timer: a 16-bit auto-reload counter that can split into
 two 8-bit auto-reload timers, or capture its count on a start-of-frame
 event or a rising edge of the low-frequency oscillator.
 Assumes a processor special-register port (address, write strobe,
 read strobe), the byte clock-select bits and the timer interrupt
 enable supplied from outside, and asynchronous event and clock pins.

// Functional notes
// - 16-bit mode: full wrap reloads, sets high flag
// - 16-bit: interrupt on each full overflow
// - 16-bit: low-byte interrupt when low enable set
// - Split: two 8-bit timers, own reload bytes
// - Split: run gates high byte only
// - Per-byte clock: system, div 12, ext div 8
// - External divided clock synchronised before counting
// - High byte wrap sets high flag, interrupts
// - Split, low enable: either byte interrupts
// - Flags cleared only by software write
// - Low byte wrap sets low flag always
// - Capture enable; source select SOF or oscillator
// - Capture 16-bit: free wrap, copy count
// - Capture split: 8-bit wraps, copy bytes
// - Control register layout, resets to zero
// - Run control stops and starts timer
// - Reload bytes read/write, reset zero
// - Count bytes read/write, reset zero
*/
`timescale 1ns/1ps
module t3rt_timer #(
	parameter int SYS_DIV = t3rt_pkg::SYS_DIV
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	input wire logic highByteClockSelect,
	input wire logic lowByteClockSelect,
	input wire logic timerIrqEnable,
	input wire logic extClockDiv8,
	input wire logic usbSofEvent,
	input wire logic lowFreqOscillator,
	output logic irqRequest
);

	// Registers
	logic [7:0] ctrlReg;
	logic [7:0] reloadLowReg;
	logic [7:0] reloadHighReg;
	logic [7:0] countLowReg;
	logic [7:0] countHighReg;
	logic [7:0] rdDataReg;

	// Next values
	logic [7:0] ctrlNext;
	logic [7:0] reloadLowNext;
	logic [7:0] reloadHighNext;
	logic [7:0] countLowNext;
	logic [7:0] countHighNext;
	logic [7:0] rdDataNext;

	// Count sources and events
	logic div12Tick;
	logic extTick;
	logic sofRise;
	logic lfoRise;

	// Slow internal count source
	t3rt_prescale #(
		.DIV(SYS_DIV)
	) u_div12 (
		.clock(clock),
		.reset_n(reset_n),
		.tick(div12Tick)
	);

	// External divided clock brought into the system clock domain
	t3rt_edge_sync u_ext_sync (
		.clock(clock),
		.reset_n(reset_n),
		.asyncIn(extClockDiv8),
		.risePulse(extTick)
	);

	// Capture event sources
	t3rt_edge_sync u_sof_sync (
		.clock(clock),
		.reset_n(reset_n),
		.asyncIn(usbSofEvent),
		.risePulse(sofRise)
	);

	t3rt_edge_sync u_lfo_sync (
		.clock(clock),
		.reset_n(reset_n),
		.asyncIn(lowFreqOscillator),
		.risePulse(lfoRise)
	);

	// Control fields
	wire highFlag = ctrlReg[t3rt_pkg::BIT_HIGH_FLAG];
	wire lowFlag = ctrlReg[t3rt_pkg::BIT_LOW_FLAG];
	wire lowIrqEnable = ctrlReg[t3rt_pkg::BIT_LOW_IRQ_EN];
	wire captureEnable = ctrlReg[t3rt_pkg::BIT_CAPTURE_EN];
	wire splitEnable = ctrlReg[t3rt_pkg::BIT_SPLIT_EN];
	wire runControl = ctrlReg[t3rt_pkg::BIT_RUN];
	wire captureSourceSelect = ctrlReg[t3rt_pkg::BIT_CAPTURE_SRC];
	wire externalClockSelect = ctrlReg[t3rt_pkg::BIT_EXT_CLK_SEL];

	// Address decode
	wire selCtrl = (sfrAddr == t3rt_pkg::ADDR_CTRL);
	wire selReloadLow = (sfrAddr == t3rt_pkg::ADDR_RELOAD_LOW);
	wire selReloadHigh = (sfrAddr == t3rt_pkg::ADDR_RELOAD_HIGH);
	wire selCountLow = (sfrAddr == t3rt_pkg::ADDR_COUNT_LOW);
	wire selCountHigh = (sfrAddr == t3rt_pkg::ADDR_COUNT_HIGH);

	wire wrCtrl = sfrWrEn & selCtrl;
	wire wrReloadLow = sfrWrEn & selReloadLow;
	wire wrReloadHigh = sfrWrEn & selReloadHigh;
	wire wrCountLow = sfrWrEn & selCountLow;
	wire wrCountHigh = sfrWrEn & selCountHigh;

	// Per-byte count source selection
	wire slowTick = externalClockSelect ? extTick : div12Tick;
	wire lowTick = lowByteClockSelect ? 1'b1 : slowTick;
	wire highTick = highByteClockSelect ? 1'b1 : slowTick;

	// Run gating; in 16-bit modes the low byte's source clocks the pair
	wire lowRun = splitEnable ? 1'b1 : runControl;
	wire highRun = runControl;

	wire lowAtMax = (countLowReg == t3rt_pkg::BYTE_MAX);
	wire highAtMax = (countHighReg == t3rt_pkg::BYTE_MAX);

	wire lowAdvance = lowRun & lowTick;
	wire highAdvance = splitEnable ? (highRun & highTick) : (lowAdvance & lowAtMax);

	// Byte rollovers from all ones
	wire lowWrap = lowAdvance & lowAtMax;
	wire highWrap = highAdvance & highAtMax;

	// Reloads only outside capture mode
	wire lowLoad = ~captureEnable & (splitEnable ? lowWrap : highWrap);
	wire highLoad = ~captureEnable & highWrap;

	// Capture strobe, one cycle per detected event
	wire eventSelected = captureSourceSelect ? lfoRise : sofRise;
	wire captureStrobe = captureEnable & eventSelected;

	// Flag setting by hardware
	wire highFlagSet = highWrap | captureStrobe;
	wire lowFlagSet = lowWrap;

	// Software write; a hardware set in the same cycle wins
	wire highFlagWritten = wrCtrl ? sfrWrData[t3rt_pkg::BIT_HIGH_FLAG] : highFlag;
	wire lowFlagWritten = wrCtrl ? sfrWrData[t3rt_pkg::BIT_LOW_FLAG] : lowFlag;
	wire highFlagNext = highFlagSet | highFlagWritten;
	wire lowFlagNext = lowFlagSet | lowFlagWritten;

	// Configuration bits are plain software storage
	wire [5:0] ctrlCfgNext = wrCtrl ? sfrWrData[t3rt_pkg::BIT_LOW_IRQ_EN:0]
		: ctrlReg[t3rt_pkg::BIT_LOW_IRQ_EN:0];

	assign ctrlNext = {highFlagNext, lowFlagNext, ctrlCfgNext};

	// Count bytes; software write takes priority over counting
	wire [7:0] lowInc = countLowReg + t3rt_pkg::BYTE_ONE;
	wire [7:0] highInc = countHighReg + t3rt_pkg::BYTE_ONE;

	assign countLowNext = wrCountLow ? sfrWrData
		: lowLoad ? reloadLowReg
		: lowAdvance ? lowInc
		: countLowReg;

	assign countHighNext = wrCountHigh ? sfrWrData
		: highLoad ? reloadHighReg
		: highAdvance ? highInc
		: countHighReg;

	// Reload bytes; capture takes priority over a software write
	assign reloadLowNext = captureStrobe ? countLowReg
		: wrReloadLow ? sfrWrData
		: reloadLowReg;

	assign reloadHighNext = captureStrobe ? countHighReg
		: wrReloadHigh ? sfrWrData
		: reloadHighReg;

	// Read data mux; unmapped addresses read as zero
	wire [7:0] readMux = selCtrl ? ctrlReg
		: selReloadLow ? reloadLowReg
		: selReloadHigh ? reloadHighReg
		: selCountLow ? countLowReg
		: selCountHigh ? countHighReg
		: t3rt_pkg::READ_NONE;

	assign rdDataNext = sfrRdEn ? readMux : rdDataReg;

	// Interrupt request: high flag always, low flag when enabled
	wire lowIrqSource = lowIrqEnable & lowFlag;
	wire irqSource = highFlag | lowIrqSource;
	assign irqRequest = timerIrqEnable & irqSource;

	// Control register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrlReg <= t3rt_pkg::CTRL_RESET;
		end else begin
			ctrlReg <= ctrlNext;
		end
	end

	// Reload register pair
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			reloadLowReg <= t3rt_pkg::BYTE_RESET;
			reloadHighReg <= t3rt_pkg::BYTE_RESET;
		end else begin
			reloadLowReg <= reloadLowNext;
			reloadHighReg <= reloadHighNext;
		end
	end

	// Count register pair
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			countLowReg <= t3rt_pkg::BYTE_RESET;
			countHighReg <= t3rt_pkg::BYTE_RESET;
		end else begin
			countLowReg <= countLowNext;
			countHighReg <= countHighNext;
		end
	end

	// Registered read data
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdDataReg <= t3rt_pkg::READ_NONE;
		end else begin
			rdDataReg <= rdDataNext;
		end
	end

	assign sfrRdData = rdDataReg;

endmodule

// ---- testbench/t3rt_timer_chk.sv ----
/*
 Port checker for the reload/capture timer.
 Bound to t3rt_timer; one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module t3rt_timer_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrRdData,
	input wire logic timerIrqEnable,
	input wire logic irqRequest
);
	wire ctlWr = sfrWrEn && sfrAddr == t3rt_pkg::ADDR_CTRL;
	wire ctlRd = sfrRdEn && !sfrWrEn && sfrAddr == t3rt_pkg::ADDR_CTRL;
	wire mapped = sfrAddr >= t3rt_pkg::ADDR_CTRL && sfrAddr <= t3rt_pkg::ADDR_COUNT_HIGH;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	chk_irq_needs_enable: assert property (!timerIrqEnable |-> !irqRequest)
		else $error("irq without enable");
	chk_reset_quiet: assert property (!$past(reset_n) |-> !irqRequest && sfrRdData == 8'h00)
		else $error("not quiet after reset");
	chk_read_holds: assert property (!sfrRdEn |=> $stable(sfrRdData))
		else $error("read data moved");
	chk_unmapped_zero: assert property (sfrRdEn && !mapped |=> sfrRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_ctrl_readback: assert property (ctlWr ##1 ctlRd |=>
		sfrRdData[5:0] == $past(sfrWrData[5:0], 2))
		else $error("ctrl readback wrong");
	chk_flag_sticky: assert property (irqRequest && !ctlWr ##1 timerIrqEnable |-> irqRequest)
		else $error("flag dropped by hardware");
	chk_high_flag_irq: assert property (ctlWr && sfrWrData[7] ##1 timerIrqEnable |-> irqRequest)
		else $error("high flag gives no irq");
	chk_low_flag_irq: assert property (ctlWr && sfrWrData[6] && sfrWrData[5]
		##1 timerIrqEnable |-> irqRequest)
		else $error("low flag gives no irq");
	cover property (ctlWr ##1 ctlRd);
	cover property ($rose(irqRequest));
	cover property (sfrRdEn && !mapped);
	cover property (ctlWr && sfrWrData[4] && sfrWrData[3]);
endmodule
bind t3rt_timer t3rt_timer_chk t3rt_timer_chk_inst (.clock(clock), .reset_n(reset_n),
	.sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
	.sfrRdData(sfrRdData), .timerIrqEnable(timerIrqEnable), .irqRequest(irqRequest));

// ---- testbench/tb.sv ----
/*
 Self-checking bench for the reload/capture timer.
 Drives the register port and event pins directly.
*/
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] CT = t3rt_pkg::ADDR_CTRL;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, hiSel = 1'b0, loSel = 1'b0;
	logic irqEn = 1'b0, ext = 1'b0, sof = 1'b0, low_frequency_oscillator = 1'b0, irq;
	logic [7:0] sfrRdData;
	int num_errors = 0;
	int comparisons = 0;
	always #5 clock = ~clock;
	t3rt_timer t3rt_timer_inst (.clock(clock), .reset_n(reset_n), .sfrAddr(sfrAddr),
		.sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
		.highByteClockSelect(hiSel), .lowByteClockSelect(loSel), .timerIrqEnable(irqEn),
		.extClockDiv8(ext), .usbSofEvent(sof), .lowFreqOscillator(low_frequency_oscillator), .irqRequest(irq));
	task automatic test_done();
		$display("counts: %0d errors, %0d checks", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, exp, got);
		end
	endtask
	// Idle wait; drops any strobe left up by the last access
	task automatic cyc(input int n);
		sfrWrEn = 1'b0;
		sfrRdEn = 1'b0;
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Strobe stays up for a following write, lowered by the next read or wait
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrRdEn = 1'b0;
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		@(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input string n, input logic [7:0] e);
		sfrWrEn = 1'b0;
		sfrAddr = a;
		sfrRdEn = 1'b1;
		@(posedge clock);
		#1;
		check(n, sfrRdData, e);
	endtask
	task automatic pulse(input logic useLfo);
		if (useLfo)
			low_frequency_oscillator = 1'b1;
		else
			sof = 1'b1;
		cyc(3);
		low_frequency_oscillator = 1'b0;
		sof = 1'b0;
		cyc(5);
	endtask
	initial begin
		#20000;
		num_errors++;
		$display("[ERR] watchdog exp 0 got 1");
		test_done();
	end
	initial begin
		logic [7:0] k;
		cyc(6);
		reset_n = 1'b1;
		for (int a = 8'h90; a <= 8'h96; a++) rd(a[7:0], "reset", 8'h00);
		wr(CT, 8'h2B);
		rd(CT, "ctrl", 8'h2B);
		wr(CT, 8'h00);
		for (int i = 0; i < 4; i++) wr(8'h92 + 8'(i), 8'hC3 ^ 8'(i));
		cyc(20);
		for (int i = 0; i < 4; i++) rd(8'h92 + 8'(i), "rw", 8'hC3 ^ 8'(i));
		$display("done registers");
		loSel = 1'b1;
		irqEn = 1'b1;
		wr(8'h92, 8'h34);
		wr(8'h93, 8'h12);
		wr(8'h94, 8'hFE);
		wr(8'h95, 8'hFF);
		wr(CT, 8'h04);
		cyc(3);
		rd(CT, "flags16", 8'hC4);
		check("irq16", {7'h00, irq}, 8'h01);
		wr(CT, 8'h80);
		rd(8'h94, "lo16", 8'h37);
		rd(8'h95, "hi16", 8'h12);
		check("irqkept", {7'h00, irq}, 8'h01);
		wr(CT, 8'h00);
		check("irqclr", {7'h00, irq}, 8'h00);
		wr(CT, 8'h60);
		check("irqlo16", {7'h00, irq}, 8'h01);
		wr(CT, 8'h00);
		$display("done reload16");
		wr(8'h92, 8'hF0);
		wr(8'h94, 8'hFE);
		wr(8'h95, 8'h77);
		wr(CT, 8'h08);
		cyc(3);
		rd(CT, "flags8", 8'h48);
		check("irq8", {7'h00, irq}, 8'h00);
		wr(CT, 8'h68);
		check("irqlow", {7'h00, irq}, 8'h01);
		wr(CT, 8'h00);
		rd(8'h94, "lo8", 8'hF4);
		rd(8'h95, "hi8", 8'h77);
		$display("done split");
		loSel = 1'b0;
		wr(8'h94, 8'h00);
		wr(CT, 8'h04);
		cyc(119);
		wr(CT, 8'h00);
		rd(8'h94, "div", 8'(120 / t3rt_pkg::SYS_DIV));
		wr(8'h94, 8'h00);
		wr(CT, 8'h05);
		repeat (5) begin
			ext = 1'b1;
			cyc(4);
			ext = 1'b0;
			cyc(4);
		end
		cyc(6);
		wr(CT, 8'h01);
		rd(8'h94, "ext", 8'h05);
		wr(8'h95, 8'h00);
		hiSel = 1'b1;
		wr(CT, 8'h0C);
		cyc(9);
		wr(CT, 8'h00);
		rd(8'h95, "hisel", 8'h0A);
		$display("done clocks");
		for (int i = 0; i < 2; i++) begin
			k = 8'(i);
			wr(8'h92, 8'h00);
			wr(8'h94, 8'hAB);
			wr(8'h95, 8'hC0 | k);
			wr(CT, 8'h10 | (k << 1));
			pulse(i == 0);
			rd(8'h92, "nocap", 8'h00);
			pulse(i == 1);
			rd(8'h92, "caplo", 8'hAB);
			rd(8'h93, "caphi", 8'hC0 | k);
			rd(CT, "capflag", 8'h90 | (k << 1));
			check("capirq", {7'h00, irq}, 8'h01);
			wr(CT, 8'h00);
		end
		loSel = 1'b1;
		wr(8'h92, 8'h33);
		wr(8'h94, 8'hFE);
		wr(8'h95, 8'h5A);
		wr(CT, 8'h18);
		pulse(1'b0);
		rd(8'h92, "capsplo", 8'h02);
		rd(8'h93, "capsphi", 8'h5A);
		rd(CT, "capspflag", 8'hD8);
		wr(CT, 8'h00);
		$display("done capture");
		test_done();
	end
endmodule
